// *** hw/bpe_hub_msg.sv ***
// Holds one system error special cycle request toward the hub interface.
// Assumes the hub side takes the request with a valid/ready handshake on aclk.
`timescale 1ns/1ps
module bpe_hub_msg (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic trigger,
   output logic msg_valid,
   input wire logic msg_ready,
   output logic msg_sent
);
   logic pending_q;

   // A trigger in the handshake cycle starts a new request so no error is lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending_q <= 1'b0;
      end else if (trigger) begin
         pending_q <= 1'b1;
      end else if (pending_q && msg_ready) begin
         pending_q <= 1'b0;
      end
   end

   assign msg_valid = pending_q;
   assign msg_sent = pending_q && msg_ready;
endmodule : bpe_hub_msg

// *** hw/bpe_pkg.sv ***
// Constants shared by the buffer parity error routing block.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package bpe_pkg;
   localparam int unsigned NUM_SRC = 4;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] SERR_EN_IDX = 8'h7c;
   localparam logic [7:0] MC_EN_IDX = 8'h7e;
   localparam logic [7:0] IRQ_STATUS_IDX = 8'h80;
   localparam logic [7:0] IRQ_MASK_IDX = 8'h81;
   localparam logic [7:0] FLAGS_VIEW_IDX = 8'h82;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] ENABLE_WRITABLE = 8'h0f;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // Interrupt status bit positions.
   localparam int unsigned IRQ_SERR_SENT = 0;
   localparam int unsigned IRQ_MC_RAISED = 1;
   // Source bit positions within the error flag and enable registers.
   localparam int unsigned SRC_WB_TO_DRAM = 0;
   localparam int unsigned SRC_WB_TO_BUS = 1;
   localparam int unsigned SRC_BUS_TO_WB = 2;
   localparam int unsigned SRC_DRAM_TO_WB = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : bpe_pkg

// *** hw/bpe_route.sv ***
// Routes the memory write buffer parity error flags to the hub interface and the machine check pin.
// Assumes error flags come from logic on aclk and software uses AXI4-Lite on the same clock.
//
// How it works
// - Set flag with its system error enable sends a hub special cycle.
// - System error enable bit 3 gates DRAM-to-buffer parity errors, flag bit 3.
// - System error enable bit 2 gates bus/IO-to-buffer parity errors, flag bit 2.
// - System error enable bit 1 gates buffer-to-bus parity errors, flag bit 1.
// - System error enable bit 0 gates buffer-to-DRAM parity errors, flag bit 0.
// - Set flag with its machine check enable asserts the machine check signal.
// - Machine check enable bit 3 gates DRAM-to-buffer parity errors, flag bit 3.
// - Machine check enable bit 2 gates bus/IO-to-buffer parity errors, flag bit 2.
// - Machine check enable bit 1 gates buffer-to-bus parity errors, flag bit 1.
// - Machine check enable bit 0 gates buffer-to-DRAM parity errors, flag bit 0.
// - System error enable register: 8 bits, index 7Ch, resets to 00h.
// - Machine check enable register: 8 bits, index 7Eh, resets to 00h.
`timescale 1ns/1ps
module bpe_route (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] buffer_first_error_flags,
   input wire logic [3:0] buffer_next_error_flags,
   output logic hub_interface_serr_valid,
   input wire logic hub_interface_serr_ready,
   output logic machine_check_signal_n,
   output logic irq
);
   logic [7:0] serr_en_q;
   logic [7:0] mc_en_q;
   logic [1:0] irq_status_q;
   logic [1:0] irq_mask_q;
   logic [3:0] flags;
   logic [3:0] serr_gate;
   logic [3:0] mc_gate;
   logic [3:0] serr_gate_prev_q;
   logic machine_check_q;
   logic serr_trigger;
   logic serr_sent;
   logic aw_held_q;
   logic w_held_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic wr_fire;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [1:0] irq_set;

   // Byte address of a register index; the bus only carries aligned words.
   function automatic logic [31:0] reg_addr(input logic [7:0] idx);
      reg_addr = {22'h000000, idx, 2'h0};
   endfunction : reg_addr

   function automatic logic is_mapped(input logic [31:0] addr);
      is_mapped = (addr == reg_addr(bpe_pkg::SERR_EN_IDX)) || (addr == reg_addr(bpe_pkg::MC_EN_IDX)) ||
         (addr == reg_addr(bpe_pkg::IRQ_STATUS_IDX)) || (addr == reg_addr(bpe_pkg::IRQ_MASK_IDX)) ||
         (addr == reg_addr(bpe_pkg::FLAGS_VIEW_IDX));
   endfunction : is_mapped

   // A first error and a later one both count as a pending source.
   assign flags = buffer_first_error_flags | buffer_next_error_flags;

   // Only one message type per source is expected from software; both paths are gated independently.
   assign serr_gate[bpe_pkg::SRC_DRAM_TO_WB] = flags[bpe_pkg::SRC_DRAM_TO_WB] & serr_en_q[3];
   assign serr_gate[bpe_pkg::SRC_BUS_TO_WB] = flags[bpe_pkg::SRC_BUS_TO_WB] & serr_en_q[2];
   assign serr_gate[bpe_pkg::SRC_WB_TO_BUS] = flags[bpe_pkg::SRC_WB_TO_BUS] & serr_en_q[1];
   assign serr_gate[bpe_pkg::SRC_WB_TO_DRAM] = flags[bpe_pkg::SRC_WB_TO_DRAM] & serr_en_q[0];
   assign mc_gate[bpe_pkg::SRC_DRAM_TO_WB] = flags[bpe_pkg::SRC_DRAM_TO_WB] & mc_en_q[3];
   assign mc_gate[bpe_pkg::SRC_BUS_TO_WB] = flags[bpe_pkg::SRC_BUS_TO_WB] & mc_en_q[2];
   assign mc_gate[bpe_pkg::SRC_WB_TO_BUS] = flags[bpe_pkg::SRC_WB_TO_BUS] & mc_en_q[1];
   assign mc_gate[bpe_pkg::SRC_WB_TO_DRAM] = flags[bpe_pkg::SRC_WB_TO_DRAM] & mc_en_q[0];

   // A special cycle is a message, so one is requested in each cycle where any source becomes newly gated, not per clock.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serr_gate_prev_q <= 4'h0;
      end else begin
         serr_gate_prev_q <= serr_gate;
      end
   end

   assign serr_trigger = |(serr_gate & ~serr_gate_prev_q);

   bpe_hub_msg u_hub_msg (
      .aclk(aclk),
      .aresetn(aresetn),
      .trigger(serr_trigger),
      .msg_valid(hub_interface_serr_valid),
      .msg_ready(hub_interface_serr_ready),
      .msg_sent(serr_sent)
   );

   // The machine check pin is a level that stays asserted while any gated flag is set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         machine_check_q <= 1'b0;
      end else begin
         machine_check_q <= |mc_gate;
      end
   end

   assign machine_check_signal_n = ~machine_check_q;

   // Write channel: address and data are held independently and joined once both are in.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 32'h00000000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
   assign wr_addr = {awaddr_q[31:2], 2'h0};
   assign wr_data = wdata_q;
   assign wr_strb = wstrb_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= bpe_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= is_mapped(wr_addr) ? bpe_pkg::RESP_OKAY : bpe_pkg::RESP_DECERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // Enable registers live in byte lane 0; upper bits are not stored.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serr_en_q <= bpe_pkg::ENABLE_RESET;
      end else if (wr_fire && wr_strb[0] && wr_addr == reg_addr(bpe_pkg::SERR_EN_IDX)) begin
         serr_en_q <= wr_data[7:0] & bpe_pkg::ENABLE_WRITABLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mc_en_q <= bpe_pkg::ENABLE_RESET;
      end else if (wr_fire && wr_strb[0] && wr_addr == reg_addr(bpe_pkg::MC_EN_IDX)) begin
         mc_en_q <= wr_data[7:0] & bpe_pkg::ENABLE_WRITABLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_q <= bpe_pkg::IRQ_RESET;
      end else if (wr_fire && wr_strb[0] && wr_addr == reg_addr(bpe_pkg::IRQ_MASK_IDX)) begin
         irq_mask_q <= wr_data[1:0];
      end
   end

   assign irq_set[bpe_pkg::IRQ_SERR_SENT] = serr_sent;
   assign irq_set[bpe_pkg::IRQ_MC_RAISED] = |mc_gate && !machine_check_q;

   // Write one to clear; a new event in the same cycle keeps its bit set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_q <= bpe_pkg::IRQ_RESET;
      end else if (wr_fire && wr_strb[0] && wr_addr == reg_addr(bpe_pkg::IRQ_STATUS_IDX)) begin
         irq_status_q <= (irq_status_q & ~wr_data[1:0]) | irq_set;
      end else begin
         irq_status_q <= irq_status_q | irq_set;
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);

   // Read channel: one outstanding read, answered the cycle after the address is taken.
   assign s_axi_arready = !rvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= bpe_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= bpe_pkg::RESP_OKAY;
         if ({s_axi_araddr[31:2], 2'h0} == reg_addr(bpe_pkg::SERR_EN_IDX)) begin
            rdata_q <= {24'h000000, serr_en_q};
         end else if ({s_axi_araddr[31:2], 2'h0} == reg_addr(bpe_pkg::MC_EN_IDX)) begin
            rdata_q <= {24'h000000, mc_en_q};
         end else if ({s_axi_araddr[31:2], 2'h0} == reg_addr(bpe_pkg::IRQ_STATUS_IDX)) begin
            rdata_q <= {30'h00000000, irq_status_q};
         end else if ({s_axi_araddr[31:2], 2'h0} == reg_addr(bpe_pkg::IRQ_MASK_IDX)) begin
            rdata_q <= {30'h00000000, irq_mask_q};
         end else if ({s_axi_araddr[31:2], 2'h0} == reg_addr(bpe_pkg::FLAGS_VIEW_IDX)) begin
            rdata_q <= {22'h000000, hub_interface_serr_valid, machine_check_q, serr_gate, flags};
         end else begin
            rdata_q <= 32'h00000000;
            rresp_q <= bpe_pkg::RESP_DECERR;
         end
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule : bpe_route

// *** tb/bpe_hub_model.sv ***
// Far-side model of the hub interface that accepts system error special cycles.
// Assumes requests stay up until taken; in slow mode each one waits three cycles.
`timescale 1ns/1ps
module bpe_hub_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic msg_valid,
   input wire logic slow,
   output logic msg_ready,
   output int n_taken
);
   logic [1:0] wait_q;
   assign msg_ready = msg_valid && (!slow || wait_q == 2'h3);
   always_ff @(posedge aclk) begin
      wait_q <= (!aresetn || msg_ready) ? 2'h0 : wait_q + 2'(msg_valid);
      n_taken <= !aresetn ? 0 : n_taken + int'(msg_ready);
   end
endmodule : bpe_hub_model

// *** tb/bpe_route_bench.sv ***
// Self-checking bench for the parity error routing block.
// Assumes the hub model on the far side; registers sit at four times their index.
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("wrong value at %0t: %s", $time, m); end end
module bpe_route_bench;
   logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, hub_interface_serr_valid, hub_interface_serr_ready, machine_check_signal_n, irq;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d, seed = 32'he;
   logic [3:0] s_axi_wstrb = 4'hf, buffer_first_error_flags = '0, buffer_next_error_flags = '0;
   logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int n_fail = 0, n_checks = 0, n_taken, exp_taken = 0, en;
   wire logic [3:0] fl = buffer_first_error_flags | buffer_next_error_flags;
   bpe_route bpe_route_i (.*);
   bpe_hub_model bpe_hub_model_i (.aclk, .aresetn, .msg_valid(hub_interface_serr_valid), .slow,
      .msg_ready(hub_interface_serr_ready), .n_taken);
   initial forever #4 aclk = ~aclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Handshakes are sampled at the falling edge, so nothing races the rising edge.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] v);
      logic ta, tw, tr, tb;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {wr, wr, !wr};
      {s_axi_bready, s_axi_rready} <= {2{rnd() > 32'h7fffffff}};
      forever begin
         @(negedge aclk);
         {ta, tw, tr} = {s_axi_awready & s_axi_awvalid, s_axi_wready & s_axi_wvalid, s_axi_arready & s_axi_arvalid};
         tb = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
         {r, d} = wr ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
         @(posedge aclk);
         s_axi_awvalid <= s_axi_awvalid & !ta;
         s_axi_wvalid <= s_axi_wvalid & !tw;
         s_axi_arvalid <= s_axi_arvalid & !tr;
         {s_axi_bready, s_axi_rready} <= {2{!tb}};
         if (tb) break;
      end
   endtask : bus
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      results();
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      bus(1'b0, 32'h1f0, '0);
      `CHK({d, machine_check_signal_n, irq}, 34'h2, "serr enable reset");
      bus(1'b0, 32'h1f8, '0);
      `CHK({r, d}, 34'h0, "mc enable reset");
      bus(1'b1, 32'h1f0, 32'hf5);
      bus(1'b0, 32'h1f0, '0);
      `CHK({r, d}, 34'h5, "serr enable upper bits");
      bus(1'b1, 32'h300, '0);
      `CHK(r, 2'h3, "unmapped write");
      bus(1'b0, 32'h300, '0);
      `CHK({r, d}, 34'h300000000, "unmapped read");
      bus(1'b1, 32'h1f0, '0);
      $display("register test done");
      for (int i = 0; i < 4; i++) begin
         en = 1 << i;
         bus(1'b1, 32'h1f8, 32'hf0 | en);
         bus(1'b0, 32'h1f8, '0);
         `CHK(d, 32'(en), "mc enable readback");
         repeat (6) begin
            @(posedge aclk);
            {buffer_first_error_flags, buffer_next_error_flags} <= 8'(rnd());
            repeat (2) @(negedge aclk);
            `CHK(machine_check_signal_n, ~|(fl & en[3:0]), "mc level");
         end
      end
      @(posedge aclk);
      {buffer_first_error_flags, buffer_next_error_flags} <= 8'h00;
      bus(1'b1, 32'h1f8, '0);
      $display("machine check test done");
      // Disabled noise bits ride along, so exactly one special cycle is due per pass.
      for (int i = 0; i < 4; i++) begin
         en = 1 << i;
         slow <= i[0];
         bus(1'b1, 32'h1f0, 32'(en));
         buffer_first_error_flags <= i[0] ? 4'h0 : 4'(en);
         buffer_next_error_flags <= (4'(rnd()) & ~4'(en)) | (i[0] ? 4'(en) : 4'h0);
         exp_taken++;
         repeat (12) @(negedge aclk);
         `CHK(n_taken, exp_taken, "special cycle count");
         @(posedge aclk);
         {buffer_first_error_flags, buffer_next_error_flags} <= 8'h00;
      end
      $display("special cycle test done");
      bus(1'b0, 32'h200, '0);
      `CHK(d[1:0], 2'h3, "status after events");
      bus(1'b1, 32'h204, 32'h1);
      `CHK(irq, 1'b1, "irq unmasked");
      bus(1'b1, 32'h200, 32'h1);
      `CHK(irq, 1'b0, "irq cleared");
      bus(1'b1, 32'h204, 32'h2);
      `CHK(irq, 1'b1, "irq second source");
      bus(1'b1, 32'h204, 32'h0);
      `CHK(irq, 1'b0, "irq masked");
      $display("interrupt test done");
      results();
   end
endmodule : bpe_route_bench

// *** tb/bpe_route_sva.sv ***
// Port checker for the parity error routing block, bound to its top module.
// Assumes one clock domain with a synchronous active low reset.
`timescale 1ns/1ps
module bpe_route_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
   input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic [3:0] buffer_first_error_flags, buffer_next_error_flags,
   input wire logic hub_interface_serr_valid, hub_interface_serr_ready, machine_check_signal_n
);
   wire logic flag = |(buffer_first_error_flags | buffer_next_error_flags);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_hub_rise;
      !hub_interface_serr_valid ##1 hub_interface_serr_valid;
   endsequence
   // Both halves taken together are joined one cycle later, so the response rises on the second edge.
   chk_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no write response");
   chk_b_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
   chk_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read response");
   chk_r_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
   chk_hub_hold: assert property (hub_interface_serr_valid && !hub_interface_serr_ready |=> hub_interface_serr_valid)
      else $error("special cycle dropped");
   chk_hub_cause: assert property (s_hub_rise |-> $past(flag)) else $error("special cycle without error");
   chk_mc_cause: assert property ($fell(machine_check_signal_n) |-> $past(flag))
      else $error("machine check without error");
   chk_mc_idle: assert property (!flag |=> machine_check_signal_n) else $error("machine check held");
endmodule : bpe_route_chk
bind bpe_route bpe_route_chk bpe_route_chk_i (.*);
